// ### rtl/ac_ctrl_params.svh
/*
 Timing counts and select field codes for the comparator control block.
 Assumes inclusion by its bare name from the design file.
*/
`ifndef AC_CTRL_PARAMS_SVH
`define AC_CTRL_PARAMS_SVH

`define AC_CLK_FREQ_HZ      20000000
`define AC_STARTUP_NS       1000
`define AC_STARTUP_CYCLES   ((`AC_STARTUP_NS * 20 + 999) / 1000)
`define AC_CHANNELS         2
`define AC_SEL_TOGGLE       2'h0
`define AC_SEL_RISE         2'h1
`define AC_SEL_FALL         2'h2
`define AC_SEL_EOC          2'h3
`define AC_SYNC_STAGES      2

`endif

// ### rtl/ac_ctrl_pkg.sv
/*
 Types for the comparator control block.
 Assumes the params header is on the include path.
*/
package ac_ctrl_pkg;
    typedef enum logic [1:0] {
        CH_OFF,
        CH_STARTUP,
        CH_RUN,
        CH_DONE
    } ch_state_t;
endpackage

// ### rtl/analog_comparator_control.sv
/*
 Per-channel control of the analog comparators: enable, start-up
 masking, continuous or one-shot measurement, interrupt condition
 selection and event output. The analog comparison sits outside; its
 raw result arrives on cmp_raw and is taken as synchronous to sys_clk.
 The comparator sampling clock is represented by a one-cycle strobe
 sample_tick; the block asks for it through sample_clk_req.
*/
// Contract
// R01 - A channel runs when its enable bit is one and stops when it is zero.
// R02 - Clearing the global enable stops all channels but keeps their bits.
// R03 - The mode bit picks continuous (zero) or one-shot (one) measurement.
// R04 - No valid result is presented while the start-up delay runs; a restart from CH_DONE keeps the previous ready flag and result set.
// R05 - In continuous mode only the first comparison waits for start-up.
// R06 - The select field picks toggle, rising, falling or end of compare.
// R07 - Events follow the output state whatever the interrupt enable.
// R08 - In continuous mode the result bit holds the latest comparison.
// R09 - After start-up a compare updates result, ready flag and events.
// R10 - Continuous comparisons go on until the channel enable is cleared.
// R11 - Edges compare present and previous sample, one per sample tick.
// R12 - In sleep an input event requests the clock and starts a compare.
// R13 - After a sleep one-shot the comparator and clock turn off unless waking.
// R14 - Continuous sleep with gated sampling clock gives no filtering.
// R15 - Each channel has input, filter, interrupt and standby fields.
// R16 - Soft reset and enable writes are synchronised before use.
// R17 - Disabling a channel clears its ready flag until a new start-up.
`timescale 1ns/1ps
`include "ac_ctrl_params.svh"

module analog_comparator_control #(
    parameter int CH           = `AC_CHANNELS,
    parameter int MUX_W        = 3,
    parameter int FILTER_LENGTH_W       = 3,
    parameter int STARTUP_CYC  = `AC_STARTUP_CYCLES
) (
    input  wire logic              sys_clk,
    input  wire logic              sys_rst,
    input  wire logic              soft_reset_bit,
    input  wire logic              global_enable,
    input  wire logic [1:0]        window_config_reg,
    input  wire logic [CH-1:0]     channel_enable,
    input  wire logic [CH-1:0]     single_shot,
    input  wire logic [CH*2-1:0]   irq_condition_select,
    input  wire logic [CH*MUX_W-1:0] positive_input_select,
    input  wire logic [CH*MUX_W-1:0] negative_input_select,
    input  wire logic [CH*FILTER_LENGTH_W-1:0] filter_length,
    input  wire logic [CH-1:0]     keep_running_asleep,
    input  wire logic [CH-1:0]     wake_enable,
    input  wire logic              sleeping,
    input  wire logic [CH-1:0]     start_event,
    input  wire logic              sample_tick,
    input  wire logic [CH-1:0]     cmp_raw,
    output logic [CH-1:0]          cmp_power_on,
    output logic                   sample_clk_req,
    output logic [CH*MUX_W-1:0]    mux_pos_out,
    output logic [CH*MUX_W-1:0]    mux_neg_out,
    output logic [CH*FILTER_LENGTH_W-1:0]   filter_len_out,
    output logic [1:0]             window_out,
    output logic [CH-1:0]          live_result_reg,
    output logic [CH-1:0]          ready_flags_reg,
    output logic [CH-1:0]          cmp_event,
    output logic [CH-1:0]          irq_flag,
    output logic [CH-1:0]          wake_req
);

    // R16 enable sync
    logic [CH-1:0] en_s1_reg;
    logic [CH-1:0] en_s2_reg;
    logic          gen_s1_reg;
    logic          gen_s2_reg;
    logic          srst_s1_reg;
    logic          srst_s2_reg;
    logic [1:0]    win_s1_reg;
    logic [1:0]    win_s2_reg;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            en_s1_reg   <= '0;
            en_s2_reg   <= '0;
            gen_s1_reg  <= 1'b0;
            gen_s2_reg  <= 1'b0;
            srst_s1_reg <= 1'b0;
            srst_s2_reg <= 1'b0;
            win_s1_reg  <= 2'h0;
            win_s2_reg  <= 2'h0;
        end else begin
            en_s1_reg   <= channel_enable;
            en_s2_reg   <= en_s1_reg;
            gen_s1_reg  <= global_enable;
            gen_s2_reg  <= gen_s1_reg;
            srst_s1_reg <= soft_reset_bit;
            srst_s2_reg <= srst_s1_reg;
            win_s1_reg  <= window_config_reg;
            win_s2_reg  <= win_s1_reg;
        end
    end

    // Window config is applied only once synchronised
    assign window_out = win_s2_reg;
    assign sample_clk_req = |cmp_power_on;

    genvar g;
    generate
        for (g = 0; g < CH; g++) begin : gen_ch
            ac_ctrl_pkg::ch_state_t state_reg;
            logic [15:0] cnt_reg;
            logic        prev_reg;
            logic        armed_reg;
            logic        active;
            logic        sleep_cont;
            logic        compare;
            logic        cur;
            logic [1:0]  sel;
            logic        hit;

            // R02 global gate
            // R01 channel enable
            assign active = gen_s2_reg && en_s2_reg[g] && !srst_s2_reg;
            assign sel    = irq_condition_select[g*2 +: 2];
            assign cur    = cmp_raw[g];
            // R15 channel fields
            assign mux_pos_out[g*MUX_W +: MUX_W] =
                positive_input_select[g*MUX_W +: MUX_W];
            assign mux_neg_out[g*MUX_W +: MUX_W] =
                negative_input_select[g*MUX_W +: MUX_W];
            // R14 no filter asleep
            assign sleep_cont = sleeping && !single_shot[g]
                && !keep_running_asleep[g];
            assign filter_len_out[g*FILTER_LENGTH_W +: FILTER_LENGTH_W] = sleep_cont
                ? '0 : filter_length[g*FILTER_LENGTH_W +: FILTER_LENGTH_W];
            // R11 one sample per tick
            assign compare = sample_tick &&
                ((state_reg == ac_ctrl_pkg::CH_RUN) ||
                 (state_reg == ac_ctrl_pkg::CH_STARTUP &&
                  cnt_reg == 16'h0000));

            // R06 condition select
            always_comb begin
                hit = 1'b0;
                if (sel == `AC_SEL_TOGGLE) begin
                    hit = armed_reg && (cur != prev_reg);
                end else if (sel == `AC_SEL_RISE) begin
                    hit = armed_reg && cur && !prev_reg;
                end else if (sel == `AC_SEL_FALL) begin
                    hit = armed_reg && !cur && prev_reg;
                end else begin
                    hit = 1'b1;
                end
            end

            always_ff @(posedge sys_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    state_reg <= ac_ctrl_pkg::CH_OFF;
                    cnt_reg   <= 16'h0000;
                end else if (!active) begin
                    state_reg <= ac_ctrl_pkg::CH_OFF;
                    cnt_reg   <= 16'h0000;
                end else begin
                    case (state_reg)
                        ac_ctrl_pkg::CH_OFF: begin
                            // R12 sleep event start
                            // R03 mode select
                            if (!single_shot[g] || start_event[g]) begin
                                state_reg <= ac_ctrl_pkg::CH_STARTUP;
                                cnt_reg   <= 16'(STARTUP_CYC - 1);
                            end
                        end
                        ac_ctrl_pkg::CH_STARTUP: begin
                            // R04 start-up wait
                            if (cnt_reg != 16'h0000) begin
                                cnt_reg <= cnt_reg - 16'h0001;
                            end else if (compare) begin
                                // R05 only first waits
                                state_reg <= single_shot[g]
                                    ? ac_ctrl_pkg::CH_DONE
                                    : ac_ctrl_pkg::CH_RUN;
                            end
                        end
                        ac_ctrl_pkg::CH_RUN: begin
                            // R10 runs until disabled
                            if (single_shot[g]) begin
                                state_reg <= ac_ctrl_pkg::CH_DONE;
                            end
                        end
                        ac_ctrl_pkg::CH_DONE: begin
                            // R13 auto power-down
                            if (start_event[g]) begin
                                state_reg <= ac_ctrl_pkg::CH_STARTUP;
                                cnt_reg   <= 16'(STARTUP_CYC - 1);
                            end
                        end
                        default: begin
                            state_reg <= ac_ctrl_pkg::CH_OFF;
                        end
                    endcase
                end
            end

            // R13 stay on when waking
            always_ff @(posedge sys_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    cmp_power_on[g] <= 1'b0;
                end else begin
                    cmp_power_on[g] <= active &&
                        (state_reg == ac_ctrl_pkg::CH_STARTUP ||
                         state_reg == ac_ctrl_pkg::CH_RUN ||
                         (state_reg == ac_ctrl_pkg::CH_DONE &&
                          (!sleeping || wake_enable[g])));
                end
            end

            // R08 latest result
            // R09 compare updates
            always_ff @(posedge sys_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    live_result_reg[g] <= 1'b0;
                    prev_reg           <= 1'b0;
                    armed_reg          <= 1'b0;
                end else if (!active) begin
                    armed_reg <= 1'b0;
                end else if (compare) begin
                    live_result_reg[g] <= cur;
                    prev_reg           <= cur;
                    armed_reg          <= !single_shot[g];
                end
            end

            // R17 ready cleared on disable
            always_ff @(posedge sys_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    ready_flags_reg[g] <= 1'b0;
                end else if (!active) begin
                    ready_flags_reg[g] <= 1'b0;
                end else if (compare) begin
                    ready_flags_reg[g] <= 1'b1;
                end
            end

            // R07 events ignore irq enable
            always_ff @(posedge sys_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    cmp_event[g] <= 1'b0;
                    irq_flag[g]  <= 1'b0;
                    wake_req[g]  <= 1'b0;
                end else begin
                    cmp_event[g] <= active && compare && cur;
                    irq_flag[g]  <= active && compare && hit;
                    wake_req[g]  <= active && compare && hit
                        && sleeping && wake_enable[g];
                end
            end
        end
    endgenerate

endmodule

// ### tb/analog_comparator_control_chk.sv
/* Port checker for the comparator control block.
   Assumes a bind to the top module and a sample tick no faster than
   one in four cycles. */
`timescale 1ns/1ps
module analog_comparator_control_chk #(
    parameter int CH    = 2,
    parameter int MUX_W = 3
) (
    input wire logic               sys_clk,
    input wire logic               sys_rst,
    input wire logic               global_enable,
    input wire logic [1:0]         window_config_reg,
    input wire logic [CH*2-1:0]    irq_condition_select,
    input wire logic [CH*MUX_W-1:0] positive_input_select,
    input wire logic [CH*MUX_W-1:0] negative_input_select,
    input wire logic [CH-1:0]      cmp_power_on,
    input wire logic               sample_clk_req,
    input wire logic [CH*MUX_W-1:0] mux_pos_out,
    input wire logic [CH*MUX_W-1:0] mux_neg_out,
    input wire logic [1:0]         window_out,
    input wire logic [CH-1:0]      live_result_reg,
    input wire logic [CH-1:0]      ready_flags_reg,
    input wire logic [CH-1:0]      cmp_event,
    input wire logic [CH-1:0]      irq_flag
);
    logic [1:0] age_reg;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    // Past values before reset release are not trusted
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) age_reg <= 2'h0;
        else if (age_reg != 2'h3) age_reg <= age_reg + 2'h1;
    end
    property p_mux_pos; mux_pos_out == positive_input_select; endproperty
    a_mux_pos: assert property (p_mux_pos) else $error("pos mux");
    property p_mux_neg; mux_neg_out == negative_input_select; endproperty
    a_mux_neg: assert property (p_mux_neg) else $error("neg mux");
    property p_off; (!global_enable) [*4] |-> cmp_power_on == '0; endproperty
    a_off: assert property (p_off) else $error("power on");
    property p_rdy_clr; (!global_enable) [*4] |-> !ready_flags_reg; endproperty
    a_rdy_clr: assert property (p_rdy_clr) else $error("ready");
    property p_clk_req; sample_clk_req == |cmp_power_on; endproperty
    a_clk_req: assert property (p_clk_req) else $error("clk req");
    property p_evt; (cmp_event & ~ready_flags_reg) == '0; endproperty
    a_evt: assert property (p_evt) else $error("event early");
    property p_win; age_reg == 2'h3 |-> window_out == $past(window_config_reg, 2);
    endproperty
    a_win: assert property (p_win) else $error("window sync");
    // Power rises one edge after start-up begins, so from CH_OFF no result is ready yet; a restart from CH_DONE keeps the old ready flag
    property p_start; $rose(cmp_power_on[0])
        |-> !ready_flags_reg[0]; endproperty
    a_start: assert property (p_start) else $error("no startup");
    property p_rise; irq_flag[0] && irq_condition_select[1:0] == 2'h1
        |-> live_result_reg[0]; endproperty
    a_rise: assert property (p_rise) else $error("rise irq");
    property p_fall; irq_flag[0] && irq_condition_select[1:0] == 2'h2
        |-> !live_result_reg[0]; endproperty
    a_fall: assert property (p_fall) else $error("fall irq");
endmodule
bind analog_comparator_control analog_comparator_control_chk #(.CH(CH),
    .MUX_W(MUX_W)) i_chk (.sys_clk, .sys_rst, .global_enable,
    .window_config_reg, .irq_condition_select, .positive_input_select,
    .negative_input_select, .cmp_power_on, .sample_clk_req, .mux_pos_out,
    .mux_neg_out, .window_out, .live_result_reg, .ready_flags_reg,
    .cmp_event, .irq_flag);

// ### tb/test_analog_comparator_control.sv
/* Self-checking bench for the comparator control block.
   Assumes the design accepts STARTUP_CYC of 2 and two channels. */
`timescale 1ns/1ps
module test_analog_comparator_control;
    logic       sys_clk = 0, sys_rst = 1, soft_reset_bit = 0, sleeping = 0;
    logic       global_enable = 0, sample_tick = 0, sample_clk_req;
    logic [1:0] channel_enable = 0, single_shot = 0, keep_running_asleep = 0;
    logic [1:0] wake_enable = 0, start_event = 0, cmp_raw = 0, wake_req;
    logic [1:0] window_config_reg, window_out, cmp_power_on, irq_flag;
    logic [1:0] live_result_reg, ready_flags_reg, cmp_event;
    logic [3:0] irq_condition_select = 0;
    logic [5:0] positive_input_select, negative_input_select, filter_length;
    logic [5:0] mux_pos_out, mux_neg_out, filter_len_out, seq;
    int         fails = 0, checks = 0, icnt, ecnt, tcnt = 0, exp_irq, ones;
    int         k, s, wcnt = 0;
    integer     seed = 32'hB00FE28D;
    analog_comparator_control #(.STARTUP_CYC(2)) i_dut (.sys_clk, .sys_rst,
        .soft_reset_bit, .global_enable, .window_config_reg, .channel_enable,
        .single_shot, .irq_condition_select, .positive_input_select,
        .negative_input_select, .filter_length, .keep_running_asleep,
        .wake_enable, .sleeping, .start_event, .sample_tick, .cmp_raw,
        .cmp_power_on, .sample_clk_req, .mux_pos_out, .mux_neg_out,
        .filter_len_out, .window_out, .live_result_reg, .ready_flags_reg,
        .cmp_event, .irq_flag, .wake_req);
    always #25 sys_clk = ~sys_clk;
    // Sparse ticks so every result stands long enough to see
    always @(posedge sys_clk) begin
        tcnt <= tcnt + 1;
        sample_tick <= (tcnt % 4 == 0);
        if (irq_flag[0] === 1'b1) icnt++;
        if (cmp_event[0] === 1'b1) ecnt++;
        if (wake_req[1] === 1'b1) wcnt++;
    end
    task cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t got %0h expected %0h", $time, got, exp);
        end
    endtask
    task print_verdict;
        if (fails == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        {window_config_reg, filter_length, negative_input_select,
            positive_input_select} = 20'($random(seed));
        cyc(16);
        sys_rst <= 0;
        global_enable <= 1;
        for (s = 0; s < 4; s++) begin
            // First sample low so no event leaks into the counted span
            seq = 6'($random(seed)) & 6'h3E;
            cmp_raw <= {1'b0, seq[0]};
            irq_condition_select <= 4'(s);
            channel_enable <= 2'h1;
            cyc(40);
            @(negedge sys_clk);
            chk(ready_flags_reg[0], 1);
            icnt = 0;
            ecnt = 0;
            exp_irq = 0;
            ones = 0;
            for (k = 1; k < 6; k++) begin
                @(posedge sys_clk);
                cmp_raw[0] <= seq[k];
                ones += seq[k];
                if (s == 0) exp_irq += int'(seq[k] != seq[k-1]);
                if (s == 1) exp_irq += int'(seq[k] && !seq[k-1]);
                if (s == 2) exp_irq += int'(!seq[k] && seq[k-1]);
                cyc(12);
                @(negedge sys_clk);
                chk(live_result_reg[0], seq[k]);
            end
            if (s == 3) chk(icnt >= 5, 1);
            else chk(icnt, exp_irq);
            chk(ecnt != 0, ones != 0);
            @(posedge sys_clk);
            channel_enable <= 2'h0;
            cyc(6);
            @(negedge sys_clk);
            chk({ready_flags_reg[0], cmp_power_on[0]}, 0);
        end
        @(posedge sys_clk);
        channel_enable <= 2'h1;
        cyc(40);
        global_enable <= 0;
        cyc(6);
        @(negedge sys_clk);
        chk({ready_flags_reg[0], cmp_power_on[0]}, 0);
        @(posedge sys_clk);
        global_enable <= 1;
        cyc(40);
        @(negedge sys_clk);
        chk(ready_flags_reg[0], 1);
        chk(window_out, window_config_reg);
        @(posedge sys_clk);
        {channel_enable, single_shot, sleeping, cmp_raw} <= 7'h77;
        irq_condition_select <= 4'hC;
        cyc(10);
        for (k = 0; k < 2; k++) begin
            start_event <= 2'h2;
            cyc(1);
            start_event <= 2'h0;
            cyc(40);
            @(negedge sys_clk);
            chk({ready_flags_reg[1], live_result_reg[1]}, 3);
            chk(cmp_power_on[1], k);
            chk(wcnt, k);
            @(posedge sys_clk);
            wake_enable <= 2'h2;
        end
        chk(filter_len_out[2:0], 0);
        keep_running_asleep <= 2'h1;
        cyc(3);
        @(negedge sys_clk);
        chk(filter_len_out[2:0], filter_length[2:0]);
        @(posedge sys_clk);
        soft_reset_bit <= 1;
        cyc(6);
        @(negedge sys_clk);
        chk(cmp_power_on, 0);
        print_verdict;
    end
    initial begin
        cyc(5000);
        fails++;
        print_verdict;
    end
endmodule
